// ### src/imsc_cfg.svh
`ifndef IMSC_CFG_SVH
`define IMSC_CFG_SVH
// ==========================================================
// Register map, byte addresses on the AXI4-Lite port
`define IMSC_IDX_BASE    8'h00
`define IMSC_LEN_BASE    8'h40
`define IMSC_BAS_BASE    8'h80
`define IMSC_STAT_OFF    8'hC0
`define IMSC_CTRL_OFF    8'hC4
// ==========================================================
// Field positions
`define IMSC_STAT_ILL    0
`define IMSC_STAT_PEND   2:1
`define IMSC_CTRL_EXT    0
// ==========================================================
// Reset values and constants
`define IMSC_WORD_RST    32'h0000_0000
`define IMSC_CLS_MODIFY  2'h2
`define IMSC_LAT_INT     2'h1
`define IMSC_LAT_EXT     2'h2
`define IMSC_RESP_OKAY   2'h0
`define IMSC_RESP_SLVERR 2'h2
`endif

// ### src/imsc_pkg.sv
package imsc_pkg;
  // ========================================================
  // Instruction classes, one-hot
  typedef enum logic [3:0] {
    IMSC_OP_NONE   = 4'h1,
    IMSC_OP_MODIFY = 4'h2,
    IMSC_OP_STACK  = 4'h4,
    IMSC_OP_CACHE  = 4'h8
  } imsc_op_t;

  // Instruction issued by the sequencer
  typedef struct packed {
    imsc_op_t    op;
    logic [1:0]  op_class_field;
    logic        bank;
    logic        bitrev;
    logic [2:0]  src;
    logic [2:0]  dst;
    logic        dst_given;
    logic [31:0] imm;
    logic        lpu, lpo, spu, spo, ppu, ppo;
    logic        conflict_cache_clear;
    logic        icache_inval_bit;
    logic        dcache_inval_bit, dcache_wback_bit;
    logic        pcache_inval_bit, pcache_wback_bit;
  } imsc_insn_t;

  // Stack strobes
  typedef struct packed {
    logic loop_push, loop_pop, sts_push, sts_pop, pc_push, pc_pop;
  } imsc_stk_t;

  // Cache maintenance strobes
  typedef struct packed {
    logic ic_inval, dc_inval, dc_wback, pc_inval, pc_wback, pc_flush;
  } imsc_cmo_t;
endpackage

// ### src/imsc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "imsc_cfg.svh"

// Summary of operation
// - Modify adds 32-bit immediate to source index, writes destination, no address.
// - Without a destination, the source index register receives the result.
// - Nonzero length forces circular wraparound regardless of buffer enable.
// - Bit-reverse form reverses the modified value before write-back.
// - Bank bit 0 picks first generator indexes, 1 picks second.
// - Op class field value 10 decodes as immediate modify.
// - Stack instruction pushes or pops loop, status, PC stacks, may clear cache.
// - Pushes combine, pops combine, but push with pop is never issued.
// - Conflict-cache clear invalidates every entry.
// - Clear lands after one instruction internal, two external.
// - L1 cache operations stand alone, never combined with others.
// - Writeback, invalidate for data and program caches, flush for program cache only, by bit pairs.
// - Instruction cache invalidate acts on one line only.
// - Status stack pair: 10 push, 01 pop, 00 nothing.
// - Data cache pair: 10 invalidate, 01 and 11 writeback, 00 nothing.
// - Program cache pair: 10 invalidate, 01 writeback, 11 flush.
// - Loop stack pair: 10 push, 01 pop, 00 nothing.
// - PC stack pair: 10 push, 01 pop, 00 nothing.
module imsc_decoder
  import imsc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Instruction issue
  input  wire logic        insn_valid,
  input  wire imsc_insn_t  insn,
  // Stack and cache strobes
  output var  imsc_stk_t   stk_o,
  output var  imsc_cmo_t   cmo_o,
  output var  logic [31:0] cmo_line_o,
  output var  logic        ccache_clr_o,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp
);

  // ========================================================
  // Storage
  logic [31:0] idx_r  [16];
  logic [31:0] len_r  [16];
  logic [31:0] base_r [16];
  logic        ext_r;
  logic        ill_r;
  logic [1:0]  pend_r;

  // ========================================================
  // Decode
  logic       fire_mod, fire_stk, fire_cch;
  logic [3:0] src_sel, dst_sel;
  logic       any_push, any_pop, any_cch, any_stk, illegal;
  // Class qualification and register selection
  assign fire_mod = insn_valid && insn.op == IMSC_OP_MODIFY &&
                    insn.op_class_field == `IMSC_CLS_MODIFY;
  assign src_sel  = {insn.bank, insn.src};
  assign dst_sel  = insn.dst_given ? {insn.bank, insn.dst}
                                   : src_sel;
  assign any_push = insn.lpu | insn.spu | insn.ppu;
  assign any_pop  = insn.lpo | insn.spo | insn.ppo;
  assign any_stk  = any_push | any_pop | insn.conflict_cache_clear;
  assign any_cch  = insn.icache_inval_bit | insn.dcache_inval_bit |
                    insn.dcache_wback_bit | insn.pcache_inval_bit |
                    insn.pcache_wback_bit;
  // Push with pop, or cache maintenance mixed with stack bits, is refused
  assign illegal  = insn_valid &&
                    ((insn.op == IMSC_OP_STACK && (any_push && any_pop ||
                      any_cch)) ||
                     (insn.op == IMSC_OP_CACHE && any_stk));
  assign fire_stk = insn_valid && insn.op == IMSC_OP_STACK && !illegal;
  assign fire_cch = insn_valid && insn.op == IMSC_OP_CACHE && !illegal;

  // ========================================================
  // Modify datapath
  logic [31:0] src_val, len_val, base_val, sum, off, circ_val, mod_val;
  logic [31:0] rev_val;
  logic        circ;
  // Modulo 2^32 add, then single-step wrap inside the buffer
  assign src_val  = idx_r[src_sel];
  assign len_val  = len_r[src_sel];
  assign base_val = base_r[src_sel];
  assign sum      = src_val + insn.imm;
  assign off      = sum - base_val;
  assign circ     = len_val != 32'h0000_0000;
  always_comb begin
    circ_val = sum;
    if (off >= len_val) begin
      circ_val = insn.imm[31] ? sum + len_val : sum - len_val;
    end
  end
  // Bit reversal of the modified value
  for (genvar b = 0; b < 32; b++) begin : g_rev
    assign rev_val[b] = (circ ? circ_val[31-b] : sum[31-b]);
  end
  assign mod_val = insn.bitrev ? rev_val : (circ ? circ_val : sum);

  // ========================================================
  // AXI4-Lite write channel
  logic       aw_hold_r, w_hold_r, do_wr, aw_take, w_take;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_map, wr_hit_stat, wr_hit_ctrl;
  logic [1:0] wgrp;
  logic [3:0] wsel;
  assign aw_take     = s_axi_awvalid && s_axi_awready;
  assign w_take      = s_axi_wvalid && s_axi_wready;
  assign do_wr       = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wgrp        = aw_addr_r[7:6];
  assign wsel        = aw_addr_r[5:2];
  assign wr_hit_stat = aw_addr_r == `IMSC_STAT_OFF;
  assign wr_hit_ctrl = aw_addr_r == `IMSC_CTRL_OFF;
  assign wr_map      = wgrp != 2'h3 || wr_hit_stat || wr_hit_ctrl;
  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] upd,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = upd[i*8 +: 8];
      end
    end
    return res;
  endfunction
  // Address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= `IMSC_WORD_RST;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      aw_hold_r     <= (aw_hold_r | aw_take) & !do_wr;
      w_hold_r      <= (w_hold_r | w_take) & !do_wr;
      s_axi_awready <= !((aw_hold_r | aw_take) & !do_wr);
      s_axi_wready  <= !((w_hold_r | w_take) & !do_wr);
    end
  end
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IMSC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? `IMSC_RESP_OKAY : `IMSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ========================================================
  // Index, length and base registers; the instruction wins a tie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) begin
        idx_r[i]  <= `IMSC_WORD_RST;
        len_r[i]  <= `IMSC_WORD_RST;
        base_r[i] <= `IMSC_WORD_RST;
      end
    end else begin
      if (do_wr && wgrp == 2'h0) begin
        idx_r[wsel] <= merge(idx_r[wsel], w_data_r, w_strb_r);
      end
      if (do_wr && wgrp == 2'h1) begin
        len_r[wsel] <= merge(len_r[wsel], w_data_r, w_strb_r);
      end
      if (do_wr && wgrp == 2'h2) begin
        base_r[wsel] <= merge(base_r[wsel], w_data_r, w_strb_r);
      end
      if (fire_mod) begin
        idx_r[dst_sel] <= mod_val;
      end
    end
  end
  // Control: external-memory execution selects the longer latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_r <= 1'b0;
    end else if (do_wr && wr_hit_ctrl && w_strb_r[0]) begin
      ext_r <= w_data_r[`IMSC_CTRL_EXT];
    end
  end
  // Sticky refusal flag, write one to clear; a new refusal wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ill_r <= 1'b0;
    end else if (illegal) begin
      ill_r <= 1'b1;
    end else if (do_wr && wr_hit_stat && w_strb_r[0] &&
                 w_data_r[`IMSC_STAT_ILL]) begin
      ill_r <= 1'b0;
    end
  end

  // ========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_mux;
  logic [1:0]  rgrp;
  logic [3:0]  rsel;
  assign rgrp = s_axi_araddr[7:6];
  assign rsel = s_axi_araddr[5:2];
  always_comb begin
    rd_mux = `IMSC_WORD_RST;
    case (rgrp)
      2'h0: rd_mux = idx_r[rsel];
      2'h1: rd_mux = len_r[rsel];
      2'h2: rd_mux = base_r[rsel];
      default: begin
        if (s_axi_araddr == `IMSC_STAT_OFF) begin
          rd_mux = {29'h0000_0000, pend_r, ill_r};
        end else if (s_axi_araddr == `IMSC_CTRL_OFF) begin
          rd_mux = {31'h0000_0000, ext_r};
        end
      end
    endcase
  end
  // One request at a time, answered on the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `IMSC_WORD_RST;
      s_axi_rresp   <= `IMSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (rgrp != 2'h3 || s_axi_araddr == `IMSC_STAT_OFF ||
                        s_axi_araddr == `IMSC_CTRL_OFF) ?
                       `IMSC_RESP_OKAY : `IMSC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ========================================================
  // Stack strobes, all raised together for one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stk_o <= '0;
    end else begin
      stk_o.loop_push <= fire_stk && insn.lpu && !insn.lpo;
      stk_o.loop_pop  <= fire_stk && !insn.lpu && insn.lpo;
      stk_o.sts_push  <= fire_stk && insn.spu && !insn.spo;
      stk_o.sts_pop   <= fire_stk && !insn.spu && insn.spo;
      stk_o.pc_push   <= fire_stk && insn.ppu && !insn.ppo;
      stk_o.pc_pop    <= fire_stk && !insn.ppu && insn.ppo;
    end
  end
  // Conflict-cache clear: counts following instructions down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r       <= 2'h0;
      ccache_clr_o <= 1'b0;
    end else begin
      ccache_clr_o <= insn_valid && pend_r == 2'h1;
      if (fire_stk && insn.conflict_cache_clear) begin
        pend_r <= ext_r ? `IMSC_LAT_EXT : `IMSC_LAT_INT;
      end else if (insn_valid && pend_r != 2'h0) begin
        pend_r <= pend_r - 2'h1;
      end
    end
  end
  // Cache maintenance strobes and line address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmo_o      <= '0;
      cmo_line_o <= `IMSC_WORD_RST;
    end else begin
      cmo_o.ic_inval <= fire_cch && insn.icache_inval_bit;
      cmo_o.dc_inval <= fire_cch && insn.dcache_inval_bit &&
                        !insn.dcache_wback_bit;
      cmo_o.dc_wback <= fire_cch && insn.dcache_wback_bit;
      cmo_o.pc_inval <= fire_cch && insn.pcache_inval_bit &&
                        !insn.pcache_wback_bit;
      cmo_o.pc_wback <= fire_cch && !insn.pcache_inval_bit &&
                        insn.pcache_wback_bit;
      cmo_o.pc_flush <= fire_cch && insn.pcache_inval_bit &&
                        insn.pcache_wback_bit;
      if (fire_cch) begin
        cmo_line_o <= insn.imm;
      end
    end
  end

  // ========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_plain_mod;
    fire_mod && !circ && !insn.bitrev;
  endsequence
  sequence s_clear_int;
    fire_stk && insn.conflict_cache_clear && !ext_r;
  endsequence
  modify_sum_a: assert property (s_plain_mod |=>
    idx_r[$past(dst_sel)] == $past(src_val) + $past(insn.imm))
    else $error("modify result wrong");
  default_dest_a: assert property (fire_mod && !insn.dst_given |=>
    idx_r[$past(src_sel)] == $past(mod_val))
    else $error("source not updated");
  circ_range_a: assert property (fire_mod && circ && !insn.bitrev &&
    src_val - base_val < len_val && (insn.imm < len_val ||
    -insn.imm < len_val) |-> mod_val - base_val < len_val)
    else $error("wraparound missed");
  rev_ends_a: assert property (fire_mod && insn.bitrev && !circ |->
    mod_val[31] == sum[0] && mod_val[0] == sum[31])
    else $error("bit reverse wrong");
  no_pushpop_a: assert property (!((stk_o.loop_push || stk_o.sts_push ||
    stk_o.pc_push) && (stk_o.loop_pop || stk_o.sts_pop || stk_o.pc_pop)))
    else $error("push with pop");
  stack_together_a: assert property (fire_stk && insn.lpu && insn.spu
    |=> stk_o.loop_push && stk_o.sts_push ##1 (!stk_o.loop_push ||
    $past(fire_stk && insn.lpu)))
    else $error("stack strobes split");
  clear_latency_a: assert property (s_clear_int ##1 insn_valid
    |=> ccache_clr_o)
    else $error("clear latency wrong");
  cache_alone_a: assert property (insn_valid && insn.op == IMSC_OP_CACHE
    && any_stk |=> cmo_o == '0 && ill_r)
    else $error("mixed cache op ran");
  dc_both_a: assert property (fire_cch && insn.dcache_inval_bit &&
    insn.dcache_wback_bit |=> cmo_o.dc_wback && !cmo_o.dc_inval)
    else $error("data cache pair wrong");
  pc_flush_a: assert property (fire_cch && insn.pcache_inval_bit &&
    insn.pcache_wback_bit |=> cmo_o.pc_flush && !cmo_o.pc_inval)
    else $error("program cache flush wrong");
endmodule
`default_nettype wire

// ### bench/imsc_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Program sequencer model
module imsc_seq_model
  import imsc_pkg::*;
(
  // Clock
  input  wire logic       aclk,
  // Instruction issue
  output var  logic       insn_valid,
  output var  imsc_insn_t insn
);
  // Nothing issued at time zero
  initial begin
    insn_valid = 1'b0;
    insn       = '0;
  end

  // Legal word of one class, no stack or cache bits mixed in
  function automatic imsc_insn_t blank(imsc_op_t op);
    blank                = '0;
    blank.op             = op;
    blank.op_class_field = 2'h2;
  endfunction

  // One word for one cycle, then scrambled fields while idle
  task automatic issue(input imsc_insn_t w);
    @(posedge aclk);
    insn_valid <= 1'b1;
    insn       <= w;
    @(posedge aclk);
    insn_valid <= 1'b0;
    insn       <= ~w;
  endtask

  // Two words on consecutive cycles, for back-to-back timing
  task automatic issue2(input imsc_insn_t w0, input imsc_insn_t w1);
    @(posedge aclk);
    insn_valid <= 1'b1;
    insn       <= w0;
    @(posedge aclk);
    insn       <= w1;
    @(posedge aclk);
    insn_valid <= 1'b0;
    insn       <= ~w1;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "imsc_cfg.svh"
// ==============================
// Bench for the index, stack and cache decoder
module tb_top
  import imsc_pkg::*;
;
  // Clock, reset and instruction side
  logic        aclk;
  logic        aresetn;
  logic        insn_valid;
  imsc_insn_t  insn;
  imsc_stk_t   stk_o;
  imsc_cmo_t   cmo_o;
  logic [31:0] cmo_line_o;
  logic        ccache_clr_o;
  // Register bus
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // Bookkeeping
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // Sequencer model and design
  imsc_seq_model imsc_seq_model_i (.aclk, .insn_valid, .insn);
  imsc_decoder imsc_decoder_i (
    .aclk, .aresetn, .insn_valid, .insn, .stk_o, .cmo_o, .cmo_line_o,
    .ccache_clr_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp
  );

  // 100 MHz clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // Watchdog against a hung handshake
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      wrap_up();
    end
  end

  // ==============================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] ra(input logic [7:0] b, input int n);
    ra = b + 8'(4 * n);
  endfunction

  function automatic logic [31:0] rev(input logic [31:0] v);
    rev = {<<{v}};
  endfunction

  function automatic imsc_insn_t mdf(input logic bk, input logic [2:0] s,
      input logic [2:0] d, input logic g, input logic [31:0] im,
      input logic br);
    mdf           = imsc_seq_model_i.blank(IMSC_OP_MODIFY);
    mdf.bank      = bk;
    mdf.src       = s;
    mdf.dst       = d;
    mdf.dst_given = g;
    mdf.imm       = im;
    mdf.bitrev    = br;
  endfunction

  // Write with both channels offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  // Read, data and response checked
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Issue one word, then let its strobes settle
  task automatic run(input imsc_insn_t w);
    imsc_seq_model_i.issue(w);
    #1;
  endtask

  // ==============================
  // Scenarios
  task automatic t_reset;
    rd(ra(`IMSC_IDX_BASE, 0), 32'h0, `IMSC_RESP_OKAY);
    rd(`IMSC_STAT_OFF, 32'h0, `IMSC_RESP_OKAY);
    rd(`IMSC_CTRL_OFF, 32'h0, `IMSC_RESP_OKAY);
    rd(8'hF0, 32'h0, `IMSC_RESP_SLVERR);
    wr(8'hF4, 32'h1, `IMSC_RESP_SLVERR);
    $display("reset and map test done");
  endtask

  task automatic t_modify;
    wr(ra(`IMSC_IDX_BASE, 1), 32'h100, `IMSC_RESP_OKAY);
    run(mdf(1'b0, 3'h1, 3'h6, 1'b0, 32'hFFFF_FFF0, 1'b0));
    rd(ra(`IMSC_IDX_BASE, 1), 32'hF0, `IMSC_RESP_OKAY);
    run(mdf(1'b0, 3'h1, 3'h2, 1'b1, 32'h5, 1'b0));
    rd(ra(`IMSC_IDX_BASE, 2), 32'hF5, `IMSC_RESP_OKAY);
    wr(ra(`IMSC_IDX_BASE, 9), 32'h10, `IMSC_RESP_OKAY);
    run(mdf(1'b1, 3'h1, 3'h0, 1'b0, 32'h1, 1'b0));
    rd(ra(`IMSC_IDX_BASE, 9), 32'h11, `IMSC_RESP_OKAY);
    rd(ra(`IMSC_IDX_BASE, 1), 32'hF0, `IMSC_RESP_OKAY);
    // Wrong class code must leave the register alone
    run(mdf(1'b0, 3'h1, 3'h0, 1'b0, 32'h7, 1'b0) ^ {4'h0, 2'h3, 53'h0});
    rd(ra(`IMSC_IDX_BASE, 1), 32'hF0, `IMSC_RESP_OKAY);
    rd(`IMSC_STAT_OFF, 32'h0, `IMSC_RESP_OKAY);
    $display("modify test done");
  endtask

  // Buffer 0x200..0x20F: 0x20C+8 wraps to 0x204, 0x204-8 to 0x20C
  task automatic t_circ;
    wr(ra(`IMSC_BAS_BASE, 3), 32'h200, `IMSC_RESP_OKAY);
    wr(ra(`IMSC_LEN_BASE, 3), 32'h10, `IMSC_RESP_OKAY);
    wr(ra(`IMSC_IDX_BASE, 3), 32'h20C, `IMSC_RESP_OKAY);
    run(mdf(1'b0, 3'h3, 3'h0, 1'b0, 32'h8, 1'b0));
    rd(ra(`IMSC_IDX_BASE, 3), 32'h204, `IMSC_RESP_OKAY);
    run(mdf(1'b0, 3'h3, 3'h0, 1'b0, 32'hFFFF_FFF8, 1'b0));
    rd(ra(`IMSC_IDX_BASE, 3), 32'h20C, `IMSC_RESP_OKAY);
    wr(ra(`IMSC_IDX_BASE, 4), 32'h3, `IMSC_RESP_OKAY);
    run(mdf(1'b0, 3'h4, 3'h5, 1'b1, 32'h1, 1'b1));
    rd(ra(`IMSC_IDX_BASE, 5), rev(32'h4), `IMSC_RESP_OKAY);
    rd(ra(`IMSC_IDX_BASE, 4), 32'h3, `IMSC_RESP_OKAY);
    $display("circular and bit-reverse test done");
  endtask

  task automatic t_stack;
    imsc_insn_t w;
    logic [2:0] b;
    for (int k = 0; k < 16; k++) begin
      b = 3'(k);
      w = imsc_seq_model_i.blank(IMSC_OP_STACK);
      {w.lpu, w.spu, w.ppu} = (k < 8) ? b : 3'h0;
      {w.lpo, w.spo, w.ppo} = (k < 8) ? 3'h0 : b;
      run(w);
      chk(32'(stk_o), 32'({w.lpu, w.lpo, w.spu, w.spo, w.ppu, w.ppo}));
    end
    // Push with pop is refused and flagged
    w.lpu = 1'b1;
    w.spo = 1'b1;
    run(w);
    chk(32'(stk_o), 32'h0);
    rd(`IMSC_STAT_OFF, 32'h1, `IMSC_RESP_OKAY);
    wr(`IMSC_STAT_OFF, 32'h1, `IMSC_RESP_OKAY);
    rd(`IMSC_STAT_OFF, 32'h0, `IMSC_RESP_OKAY);
    $display("stack test done");
  endtask

  // Clear lands after one following word inside, two outside
  task automatic t_clear;
    imsc_insn_t w;
    for (int e = 0; e < 2; e++) begin
      wr(`IMSC_CTRL_OFF, 32'(e), `IMSC_RESP_OKAY);
      w = imsc_seq_model_i.blank(IMSC_OP_STACK);
      w.conflict_cache_clear = 1'b1;
      w.ppu = 1'b1;
      run(w);
      chk(32'(ccache_clr_o), 32'h0);
      rd(`IMSC_STAT_OFF, 32'((e + 1) * 2), `IMSC_RESP_OKAY);
      for (int n = 0; n <= e; n++) begin
        run(imsc_seq_model_i.blank(IMSC_OP_NONE));
        chk(32'(ccache_clr_o), 32'(n == e));
      end
      @(posedge aclk);
      #1;
      chk(32'(ccache_clr_o), 32'h0);
    end
    wr(`IMSC_CTRL_OFF, 32'h0, `IMSC_RESP_OKAY);
    // Back to back: the very next word lands the clear
    imsc_seq_model_i.issue2(w, imsc_seq_model_i.blank(IMSC_OP_NONE));
    #1;
    chk(32'(ccache_clr_o), 32'h1);
    $display("conflict cache clear test done");
  endtask

  task automatic t_cache;
    imsc_insn_t w;
    logic [4:0] c;
    for (int i = 1; i < 32; i++) begin
      c = 5'(i);
      w = imsc_seq_model_i.blank(IMSC_OP_CACHE);
      {w.icache_inval_bit, w.dcache_inval_bit, w.dcache_wback_bit,
       w.pcache_inval_bit, w.pcache_wback_bit} = c;
      w.imm = 32'(i) << 5;
      run(w);
      chk(32'(cmo_o), 32'({c[4], c[3] & ~c[2], c[2], c[1] & ~c[0],
          c[0] & ~c[1], c[1] & c[0]}));
      chk(cmo_line_o, w.imm);
    end
    // Cache work mixed with a push is refused
    w.lpu = 1'b1;
    run(w);
    chk(32'(cmo_o), 32'h0);
    chk(32'(stk_o), 32'h0);
    rd(`IMSC_STAT_OFF, 32'h1, `IMSC_RESP_OKAY);
    $display("cache maintenance test done");
  endtask

  // ==============================
  // Main sequence
  initial begin
    aresetn       = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_wvalid  = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_rready  = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modify();
    t_circ();
    t_stack();
    t_clear();
    t_cache();
    wrap_up();
  end
endmodule
`default_nettype wire
